// file: testbench/ddsc_dac_model.sv
// converter model for the dds core: takes words over valid/ready and
// keeps running statistics of address steps and active samples.
// assumes the waveform table holds its own address in every entry.
module ddsc_dac_model
    import ddsc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // converter stream
    input wire logic dac_valid,
    output logic dac_ready,
    input wire ddsc_pair_s dac_data,
    // bench control and statistics
    input wire logic stall_en,
    input wire logic clr,
    output logic [9:0] min1,
    output logic [9:0] max1,
    output logic [9:0] min2,
    output logic [9:0] max2,
    output logic [15:0] n_active
);
    logic [3:0] tick;
    logic have_prev;
    ddsc_pair_s prev;
    logic [9:0] d1;
    logic [9:0] d2;

    ////////////////////////////////////////////////////////////////////////
    // slow converter refuses two cycles of four, so the buffer must fill
    assign dac_ready = !(stall_en && tick[1]);
    // steps modulo the table size, as the address wraps
    assign d1 = dac_data.first_channel[9:0] - prev.first_channel[9:0];
    assign d2 = dac_data.second_channel[9:0] - prev.second_channel[9:0];

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock)
    begin
        tick <= srst ? 4'h0 : tick + 4'h1;
        if (srst || clr)
        begin
            have_prev <= 1'b0;
            min1 <= 10'h3ff;
            max1 <= 10'h000;
            min2 <= 10'h3ff;
            max2 <= 10'h000;
            n_active <= 16'h0000;
        end
        else if (dac_valid && dac_ready)
        begin
            prev <= dac_data;
            have_prev <= 1'b1;
            if (dac_data.first_channel != IDLE_SAMPLE)
                n_active <= n_active + 16'h0001;
            if (have_prev)
            begin
                min1 <= (d1 < min1) ? d1 : min1;
                max1 <= (d1 > max1) ? d1 : max1;
                min2 <= (d2 < min2) ? d2 : min2;
                max2 <= (d2 > max2) ? d2 : max2;
            end
        end
    end
endmodule

// file: testbench/testbench.sv
// self-checking bench for the dds core: apb master tasks, register table
// rows, then waveform, coupling, burst and sweep cases.
// assumes pready answers within a few cycles and a 125 MHz clock.
module testbench
    import ddsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [31:0] wd;
        logic [31:0] exp;
        logic err;
    } ddsc_row_s;

    logic clock, srst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic er_v, dac_valid, dac_ready, stall_en, clr;
    ddsc_pair_s dac_data;
    logic [9:0] min1, max1, min2, max2;
    logic [15:0] n_active;
    int err_count = 0;
    int samples_checked = 0;
    ddsc_row_s rows [12] = '{
        '{OFS_CTRL, 1'b0, 32'h0, 32'h0000_0040, 1'b0},
        '{OFS_FREQ1, 1'b0, 32'h0, 32'h0, 1'b0},
        '{OFS_FREQ2, 1'b0, 32'h0, 32'h0, 1'b0},
        '{OFS_SWP_STEP, 1'b0, 32'h0, 32'h0000_1000, 1'b0},
        '{OFS_SWP_TIME, 1'b0, 32'h0, 32'h0000_07d0, 1'b0},
        '{OFS_BST_PERIOD, 1'b0, 32'h0, 32'h0000_01f4, 1'b0},
        '{OFS_BST_COUNT, 1'b0, 32'h0, 32'h0000_0005, 1'b0},
        '{OFS_TRIG, 1'b0, 32'h0, 32'h0, 1'b0},
        '{8'h34, 1'b0, 32'h0, 32'h0, 1'b1},
        '{8'h40, 1'b1, 32'h0000_1234, 32'h0, 1'b1},
        '{OFS_BST_COUNT, 1'b1, 32'h0000_0002, 32'h0, 1'b0},
        '{OFS_BST_COUNT, 1'b0, 32'h0, 32'h0000_0002, 1'b0}
    };

    ////////////////////////////////////////////////////////////////////////
    ddsc_core #(.SWEEP_TIME_CYC(32'h0000_07d0), .BURST_PERIOD_CYC(32'h0000_01f4)) dut_u (
        .clock(clock), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .dac_valid(dac_valid), .dac_ready(dac_ready),
        .dac_data(dac_data));
    ddsc_dac_model conv_u (
        .clock(clock), .srst(srst), .dac_valid(dac_valid), .dac_ready(dac_ready),
        .dac_data(dac_data), .stall_en(stall_en), .clr(clr), .min1(min1),
        .max1(max1), .min2(min2), .max2(max2), .n_active(n_active));

    always #4 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one apb transfer; waits for pready with a bound
    task automatic apb(input logic [7:0] addr, input logic wr, input logic [31:0] wd);
        int n;
        @(posedge clock);
        paddr <= addr;
        pwrite <= wr;
        pwdata <= wd;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            err_count++;
        rd_v = prdata;
        er_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
        apb(addr, 1'b0, 32'h0);
        check(rd_v, exp);
    endtask

    // let old words drain, clear statistics, optionally trigger, then run
    task automatic measure(input int n, input logic trig);
        repeat (20) @(posedge clock);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        if (trig)
            apb(OFS_TRIG, 1'b1, 32'h1);
        repeat (n) @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (60000) @(posedge clock);
        err_count++;
        close_out();
    end

    initial
    begin
        clock = 1'b0;
        srst = 1'b1;
        {psel, penable, pwrite, stall_en, clr} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        foreach (rows[i])
        begin
            apb(rows[i].addr, rows[i].wr, rows[i].wd);
            check({31'h0, er_v}, {31'h0, rows[i].err});
            if (!rows[i].wr && !rows[i].err)
                check(rd_v, rows[i].exp);
        end
        $display("test registers done");
        // table entry equals its own address, so steps are readable
        apb(OFS_WAVE_ADDR, 1'b1, 32'h0);
        for (int i = 0; i < 1024; i++)
            apb(OFS_WAVE_DATA, 1'b1, 32'(i));
        apb(OFS_WAVE_ADDR, 1'b1, 32'h5);
        rdchk(OFS_WAVE_DATA, 32'h5);
        stall_en <= 1'b1;
        apb(OFS_FREQ1, 1'b1, 32'h0040_0000);
        apb(OFS_FREQ2, 1'b1, 32'h00c0_0000);
        measure(1200, 1'b0);
        check({min1, max1}, {10'h001, 10'h001});
        check({min2, max2}, {10'h003, 10'h003});
        $display("test stream done");
        stall_en <= 1'b0;
        apb(OFS_CTRL, 1'b1, 32'h0000_0048);
        apb(OFS_FREQ1, 1'b1, 32'h0080_0000);
        apb(OFS_FREQ2, 1'b1, 32'h0140_0000);
        rdchk(OFS_FREQ2, 32'h0080_0000);
        measure(200, 1'b0);
        check({min1, max1, min2, max2}, {4{10'h002}});
        apb(OFS_FREQ1, 1'b1, 32'h0180_0000);
        measure(200, 1'b0);
        check({min2, max2}, {10'h006, 10'h006});
        apb(OFS_CTRL, 1'b1, 32'h0000_0040);
        rdchk(OFS_FREQ2, 32'h00c0_0000);
        measure(200, 1'b0);
        check({min2, max2}, {10'h003, 10'h003});
        $display("test coupling done");
        // four samples per cycle, two cycles per burst
        apb(OFS_FREQ1, 1'b1, 32'h4000_0000);
        apb(OFS_CTRL, 1'b1, 32'h0000_0046);
        measure(50, 1'b0);
        check({16'h0, n_active}, 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            stall_en <= k[0];
            measure(100, 1'b1);
            check({16'h0, n_active}, 32'h8);
        end
        rdchk(OFS_STATUS, 32'h3);
        stall_en <= 1'b0;
        apb(OFS_BST_PERIOD, 1'b1, 32'h64);
        apb(OFS_CTRL, 1'b1, 32'h0000_0042);
        measure(1000, 1'b1);
        check({31'h0, n_active >= 72 && n_active <= 88}, 32'h1);
        $display("test burst done");
        apb(OFS_SWP_START, 1'b1, 32'h0040_0000);
        apb(OFS_SWP_STOP, 1'b1, 32'h0100_0000);
        apb(OFS_SWP_STEP, 1'b1, 32'h8);
        apb(OFS_CTRL, 1'b1, 32'h0000_0041);
        measure(2500, 1'b0);
        check({min1, max1}, {10'h001, 10'h004});
        $display("test sweep done");
        close_out();
    end
endmodule

// file: verilog/ddsc_buffer.sv
// small valid/ready buffer between the sample pipeline and the converter.
// assumes depth is a power of two; both sides synchronous to clock.
module ddsc_buffer #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] fill;
    logic push;
    logic pop;

    // compare at the counter's own width so a full count of DEPTH is not truncated
    assign in_ready = (fill != (PW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = store[rd_ptr];

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock)
    begin
        if (push)
            store[wr_ptr] <= in_data;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + PW'(1);
            if (pop)
                rd_ptr <= rd_ptr + PW'(1);
            if (push && !pop)
                fill <= fill + (PW+1)'(1);
            else if (pop && !push)
                fill <= fill - (PW+1)'(1);
        end
    end

endmodule

// file: verilog/ddsc_core.sv
// two-channel dds synthesis core with log sweep, counted bursts and
// frequency coupling, configured over apb.
// assumes the converter side accepts words via valid/ready on clock.
//
// The implementer's own choices: register access over APB and the address map.

module ddsc_core
    import ddsc_pkg::*;
#(
    parameter int MEM_AW = 10,
    parameter int BUF_DEPTH = 2,
    parameter logic [31:0] SWEEP_TIME_CYC = 32'(SWEEP_CYCLES),
    parameter logic [31:0] BURST_PERIOD_CYC = 32'(BURST_CYCLES)
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // converter stream
    output logic dac_valid,
    input wire logic dac_ready,
    output ddsc_pair_s dac_data
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [8:0] ctrl;
    logic [ACC_W-1:0] freq1;
    logic [ACC_W-1:0] freq2;
    logic [ACC_W-1:0] swp_start;
    logic [ACC_W-1:0] swp_stop;
    logic [31:0] swp_time;
    logic [31:0] swp_step;
    logic [31:0] bst_period;
    logic [CNT_W-1:0] bst_count;
    logic [MEM_AW-1:0] wave_addr;
    logic [SAMPLE_W-1:0] wave_mem [0:(1<<MEM_AW)-1];

    logic wr;
    logic hit;
    logic [31:0] rd_mux;
    logic [1:0] mode;
    logic manual_src;
    logic couple;
    logic [4:0] shift;

    assign mode = ctrl[CTRL_MODE_LSB +: 2];
    assign manual_src = ctrl[CTRL_SRC_BIT];
    assign couple = ctrl[CTRL_CPL_BIT];
    assign shift = ctrl[CTRL_SHIFT_LSB +: 5];
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;

    // datapath state
    logic [ACC_W-1:0] acc1;
    logic [ACC_W-1:0] acc2;
    logic [ACC_W-1:0] inc1;
    logic [ACC_W-1:0] inc2;
    logic [ACC_W:0] sum1;
    logic wrap1;
    logic [ACC_W-1:0] sweep_inc;
    logic [31:0] elapsed;
    logic [31:0] step_cnt;
    logic [31:0] period_cnt;
    logic [CNT_W-1:0] cycles_left;
    logic burst_on;
    logic idle;
    logic trig_manual;
    logic trig_int;
    logic trig;
    logic s_valid;
    ddsc_pair_s s_pair;
    logic buf_ready;
    logic adv;

    ////////////////////////////////////////////////////////////////////////
    // apb write side
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ctrl <= CTRL_RST;
            freq1 <= FREQ_RST;
            swp_start <= FREQ_RST;
            swp_stop <= FREQ_RST;
            swp_time <= SWEEP_TIME_CYC;
            swp_step <= SWP_STEP_RST;
            bst_period <= BURST_PERIOD_CYC;
            bst_count <= BST_COUNT_RST;
        end
        else if (wr)
        begin
            case (paddr)
                OFS_CTRL: ctrl <= pwdata[8:0];
                OFS_FREQ1: freq1 <= pwdata;
                OFS_SWP_START: swp_start <= pwdata;
                OFS_SWP_STOP: swp_stop <= pwdata;
                OFS_SWP_TIME: swp_time <= pwdata;
                OFS_SWP_STEP: swp_step <= pwdata;
                OFS_BST_PERIOD: bst_period <= pwdata;
                OFS_BST_COUNT: bst_count <= pwdata[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // second channel holds its own value through coupling, so uncoupling
    // returns to the last independently written frequency
    always_ff @(posedge clock)
    begin
        if (srst)
            freq2 <= FREQ_RST;
        else if (wr && paddr == OFS_FREQ2 && !couple)
            freq2 <= pwdata;
    end

    // memory has no reset; contents are software's to load
    always_ff @(posedge clock)
    begin
        if (wr && paddr == OFS_WAVE_DATA)
            wave_mem[wave_addr] <= pwdata[SAMPLE_W-1:0];
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            wave_addr <= '0;
        else if (wr && paddr == OFS_WAVE_ADDR)
            wave_addr <= pwdata[MEM_AW-1:0];
        else if (wr && paddr == OFS_WAVE_DATA)
            wave_addr <= wave_addr + MEM_AW'(1);
    end

    ////////////////////////////////////////////////////////////////////////
    // apb read side: data captured in setup, so the access needs no wait
    always_comb
    begin
        hit = 1'b1;
        rd_mux = 32'h0;
        case (paddr)
            OFS_CTRL: rd_mux = {23'h0, ctrl};
            OFS_FREQ1: rd_mux = freq1;
            OFS_FREQ2: rd_mux = inc2;
            OFS_SWP_START: rd_mux = swp_start;
            OFS_SWP_STOP: rd_mux = swp_stop;
            OFS_SWP_TIME: rd_mux = swp_time;
            OFS_SWP_STEP: rd_mux = swp_step;
            OFS_BST_PERIOD: rd_mux = bst_period;
            OFS_BST_COUNT: rd_mux = {16'h0, bst_count};
            OFS_TRIG: rd_mux = 32'h0;
            OFS_WAVE_ADDR: rd_mux = 32'(wave_addr);
            OFS_WAVE_DATA: rd_mux = 32'(wave_mem[wave_addr]);
            OFS_STATUS: rd_mux = {cycles_left, 14'h0, burst_on, idle};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata <= rd_mux;
            pslverr <= !hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // increments: sweep overrides the first channel, coupling copies it
    assign inc1 = (mode == MODE_SWEEP) ? sweep_inc : freq1;
    assign inc2 = couple ? inc1 : freq2;

    // log sweep: each step multiplies the increment by 1 + 2^-shift
    logic [ACC_W:0] grow;
    logic [ACC_W-1:0] next_sweep_inc;
    assign grow = {1'b0, sweep_inc} + {1'b0, sweep_inc >> shift};
    assign next_sweep_inc = (grow > {1'b0, swp_stop}) ? swp_stop : grow[ACC_W-1:0];

    always_ff @(posedge clock)
    begin
        if (srst || mode != MODE_SWEEP)
        begin
            sweep_inc <= swp_start;
            elapsed <= 32'h0;
            step_cnt <= 32'h0;
        end
        else if (elapsed >= swp_time - 32'h1)
        begin
            sweep_inc <= swp_start;
            elapsed <= 32'h0;
            step_cnt <= 32'h0;
        end
        else
        begin
            elapsed <= elapsed + 32'h1;
            if (step_cnt >= swp_step - 32'h1)
            begin
                step_cnt <= 32'h0;
                sweep_inc <= next_sweep_inc;
            end
            else
                step_cnt <= step_cnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // burst triggering
    assign burst_on = (mode == MODE_BURST);
    assign idle = burst_on && (cycles_left == '0);
    assign trig_manual = wr && paddr == OFS_TRIG && burst_on && manual_src;
    assign trig_int = burst_on && !manual_src && (period_cnt >= bst_period - 32'h1);
    assign trig = trig_manual || trig_int;

    always_ff @(posedge clock)
    begin
        if (srst || !burst_on || manual_src || trig_int)
            period_cnt <= 32'h0;
        else
            period_cnt <= period_cnt + 32'h1;
    end

    // a retrigger mid-burst restarts the count rather than queueing
    always_ff @(posedge clock)
    begin
        if (srst)
            cycles_left <= '0;
        else if (trig)
            cycles_left <= bst_count;
        else if (adv && !idle && wrap1 && burst_on)
            cycles_left <= cycles_left - CNT_W'(1);
    end

    ////////////////////////////////////////////////////////////////////////
    // phase accumulators; they stall with the converter so no word is lost
    assign sum1 = {1'b0, acc1} + {1'b0, inc1};
    assign wrap1 = sum1[ACC_W];
    assign adv = buf_ready || !s_valid;

    always_ff @(posedge clock)
    begin
        if (srst || trig)
        begin
            acc1 <= '0;
            acc2 <= '0;
        end
        else if (adv && !idle)
        begin
            acc1 <= sum1[ACC_W-1:0];
            acc2 <= acc2 + inc2;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            s_valid <= 1'b0;
            s_pair <= '0;
        end
        else if (adv)
        begin
            s_valid <= 1'b1;
            s_pair.first_channel <= idle ? IDLE_SAMPLE :
                wave_mem[acc1[ACC_W-1 -: MEM_AW]];
            s_pair.second_channel <= idle ? IDLE_SAMPLE :
                wave_mem[acc2[ACC_W-1 -: MEM_AW]];
        end
    end

    ddsc_buffer #(
        .WIDTH($bits(ddsc_pair_s)),
        .DEPTH(BUF_DEPTH)
    ) u_buffer (
        .clock(clock),
        .srst(srst),
        .in_valid(s_valid),
        .in_ready(buf_ready),
        .in_data(s_pair),
        .out_valid(dac_valid),
        .out_ready(dac_ready),
        .out_data(dac_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_manual_fire;
        burst_on && manual_src && wr && paddr == OFS_TRIG;
    endsequence

    sequence s_last_wrap;
        burst_on && !trig && adv && !idle && wrap1 && cycles_left == 16'h1
            && !(wr && paddr == OFS_CTRL);
    endsequence

    a_acc_step: assert property (adv && !idle && !trig |=>
        acc1 == $past(acc1) + $past(inc1))
        else $error("first accumulator did not add its increment");

    // table is not reset, so unwritten entries compare exactly; a table
    // write in the same cycle would move the reference under the sample
    a_sample_fetch: assert property (adv && !idle && !(wr && paddr == OFS_WAVE_DATA) |=>
        s_pair.first_channel === wave_mem[$past(acc1[ACC_W-1 -: MEM_AW])])
        else $error("sample does not match memory at accumulator address");

    a_couple_follow: assert property (couple && mode == MODE_CONT |->
        inc2 == freq1)
        else $error("second channel increment not following first");

    a_couple_ignore: assert property (couple && wr && paddr == OFS_FREQ2 |=>
        freq2 == $past(freq2))
        else $error("second channel frequency written while coupled");

    a_uncouple_own: assert property (!couple |-> inc2 == freq2)
        else $error("second channel not independent when uncoupled");

    a_manual_count: assert property (s_manual_fire |=>
        cycles_left == $past(bst_count) && acc1 == '0)
        else $error("manual trigger did not load the cycle count");

    a_burst_stop: assert property (s_last_wrap ##1 !trig |->
        idle ##1 (acc1 == $past(acc1)))
        else $error("burst did not stop after the last cycle");

    a_int_period: assert property (burst_on && !manual_src && $rose(trig_int) |=>
        cycles_left == $past(bst_count) && period_cnt == 32'h0)
        else $error("internal trigger did not restart the burst");

    a_sweep_grow: assert property (mode == MODE_SWEEP && $past(mode) == MODE_SWEEP
        && $changed(sweep_inc) |->
        sweep_inc == swp_start || sweep_inc > $past(sweep_inc))
        else $error("log sweep increment moved the wrong way");

endmodule

// file: verilog/ddsc_pkg.sv
// package for the dds channel synthesis core: register map, fields,
// reset values, timing constants and the sample-pair carrier.
// assumes a single 125 MHz sample clock shared with the apb slave.
package ddsc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int ACC_W = 32;
    localparam int SAMPLE_W = 14;
    localparam int CNT_W = 16;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FREQ1 = 8'h04;
    localparam logic [7:0] OFS_FREQ2 = 8'h08;
    localparam logic [7:0] OFS_SWP_START = 8'h0c;
    localparam logic [7:0] OFS_SWP_STOP = 8'h10;
    localparam logic [7:0] OFS_SWP_TIME = 8'h14;
    localparam logic [7:0] OFS_SWP_STEP = 8'h18;
    localparam logic [7:0] OFS_BST_PERIOD = 8'h1c;
    localparam logic [7:0] OFS_BST_COUNT = 8'h20;
    localparam logic [7:0] OFS_TRIG = 8'h24;
    localparam logic [7:0] OFS_WAVE_ADDR = 8'h28;
    localparam logic [7:0] OFS_WAVE_DATA = 8'h2c;
    localparam logic [7:0] OFS_STATUS = 8'h30;

    ////////////////////////////////////////////////////////////////////////
    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SRC_BIT = 2;
    localparam int CTRL_CPL_BIT = 3;
    localparam int CTRL_SHIFT_LSB = 4;
    localparam logic [1:0] MODE_CONT = 2'h0;
    localparam logic [1:0] MODE_SWEEP = 2'h1;
    localparam logic [1:0] MODE_BURST = 2'h2;
    localparam int STAT_LEFT_LSB = 16;

    ////////////////////////////////////////////////////////////////////////
    // reset values and timing
    localparam logic [8:0] CTRL_RST = 9'h040;
    localparam logic [ACC_W-1:0] FREQ_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] BST_COUNT_RST = 16'h0005;
    localparam logic [ACC_W-1:0] SWP_STEP_RST = 32'h0000_1000;
    localparam logic [SAMPLE_W-1:0] IDLE_SAMPLE = 14'h2000;
    localparam longint CLK_KHZ = 125000;
    localparam longint SWEEP_TIME_MS = 5000;
    localparam longint BURST_PERIOD_MS = 10;
    localparam longint SWEEP_CYCLES = SWEEP_TIME_MS * CLK_KHZ;
    localparam longint BURST_CYCLES = BURST_PERIOD_MS * CLK_KHZ;

    ////////////////////////////////////////////////////////////////////////
    // one word towards the converter: both channels side by side
    typedef struct packed {
        logic [SAMPLE_W-1:0] second_channel;
        logic [SAMPLE_W-1:0] first_channel;
    } ddsc_pair_s;

endpackage
